// *** logic/swc_host.sv ***
// Single-wire bus host: reset/presence, bit slots and byte transfers
`timescale 1ns/1ps
`include "swc_regs.svh"
module swc_host
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire swc_pkg::swc_cmd_t cmd,
   // Answer port
   output logic rsp_valid,
   input wire logic rsp_ready,
   output swc_pkg::swc_rsp_t rsp,
   // Bus pin
   input wire logic dq_in,
   output logic dq_out,
   output logic dq_oe,
   // Status
   output logic busy
);
   import swc_pkg::*;

   typedef enum logic [2:0] {
      SWC_IDLE,
      SWC_RST_LOW,
      SWC_RST_WAIT,
      SWC_SLOT,
      SWC_RECOVER,
      SWC_PUSH
   } swc_state_t;

   swc_state_t state;
   swc_op_t op;
   logic [7:0] shift;
   logic [2:0] bit_idx;
   logic [15:0] timer;
   logic [15:0] low_len;
   logic sampled;
   logic presence;
   logic last_bit;
   logic buf_in_ready;
   logic buf_out_ready;
   logic [8:0] buf_data;
   logic rsp_valid_w;
   swc_rsp_t rsp_w;

   function automatic logic [15:0] swc_low_cycles(input swc_op_t o, input logic b);
      logic [15:0] n;
      n = 16'(`SWC_RD_LOW_CYC);
      if (o == SWC_OP_WRITE_BYTE || o == SWC_OP_WRITE_BIT)
      begin
         n = b ? 16'(`SWC_W1_LOW_CYC) : 16'(`SWC_SLOT_CYC);
      end
      return n;
   endfunction

   assign low_len = swc_low_cycles(op, shift[0]);
   // A byte operation is an eight-slot transfer; the single-bit operations end after one slot
   assign last_bit = (op == SWC_OP_WRITE_BIT || op == SWC_OP_READ_BIT)
      || (bit_idx == 3'd7);
   assign buf_data = {(op == SWC_OP_READ_BIT) ? {7'd0, shift[7]} : shift, presence};
   // Output stage takes a word only when empty or being drained, so none is lost
   assign buf_out_ready = !rsp_valid || rsp_ready;

   // Answer buffer; its ready holds the engine in PUSH
   swc_skid #(.WIDTH(9)) u_buf (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(state == SWC_PUSH),
      .in_ready(buf_in_ready),
      .in_data(buf_data),
      .out_valid(rsp_valid_w),
      .out_ready(buf_out_ready),
      .out_data(rsp_w)
   );

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= SWC_IDLE;
         op <= SWC_OP_RESET;
         shift <= 8'h00;
         bit_idx <= 3'd0;
         timer <= 16'h0000;
         presence <= 1'b0;
         sampled <= 1'b0;
      end
      else
      begin
         case (state)
            SWC_IDLE:
            begin
               timer <= 16'h0000;
               if (cmd_valid)
               begin
                  op <= cmd.op;
                  shift <= cmd.data;
                  bit_idx <= 3'd0;
                  presence <= 1'b0;
                  state <= (cmd.op == SWC_OP_RESET) ? SWC_RST_LOW : SWC_SLOT;
               end
            end
            SWC_RST_LOW:
            begin
               timer <= timer + 16'd1;
               if (timer == 16'(`SWC_RST_CYC - 1))
               begin
                  timer <= 16'h0000;
                  state <= SWC_RST_WAIT;
               end
            end
            SWC_RST_WAIT:
            begin
               timer <= timer + 16'd1;
               if (timer == 16'(`SWC_PRES_SAMPLE_CYC))
               begin
                  presence <= ~dq_in;
               end
               if (timer == 16'(`SWC_PRES_CYC - 1))
               begin
                  state <= SWC_PUSH;
               end
            end
            SWC_SLOT:
            begin
               timer <= timer + 16'd1;
               if (timer == 16'(`SWC_RD_SAMPLE_CYC))
               begin
                  sampled <= dq_in;
               end
               if (timer == 16'(`SWC_SLOT_CYC - 1))
               begin
                  timer <= 16'h0000;
                  state <= SWC_RECOVER;
               end
            end
            SWC_RECOVER:
            begin
               timer <= timer + 16'd1;
               if (timer == 16'(`SWC_REC_CYC - 1))
               begin
                  timer <= 16'h0000;
                  shift <= {sampled, shift[7:1]};
                  bit_idx <= bit_idx + 3'd1;
                  state <= last_bit ? SWC_PUSH : SWC_SLOT;
               end
            end
            SWC_PUSH:
            begin
               if (buf_in_ready)
               begin
                  state <= SWC_IDLE;
               end
            end
            default: state <= SWC_IDLE;
         endcase
      end
   end

   // Open-drain pin: only ever pulls low
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dq_oe <= 1'b0;
         dq_out <= 1'b0;
      end
      else
      begin
         dq_out <= 1'b0;
         if (state == SWC_IDLE && cmd_valid && cmd.op == SWC_OP_RESET)
         begin
            dq_oe <= 1'b1;
         end
         else if (state == SWC_IDLE && cmd_valid)
         begin
            dq_oe <= 1'b1;
         end
         else if (state == SWC_RST_LOW)
         begin
            dq_oe <= (timer != 16'(`SWC_RST_CYC - 1));
         end
         else if (state == SWC_RECOVER && timer == 16'(`SWC_REC_CYC - 1) && !last_bit)
         begin
            dq_oe <= 1'b1;
         end
         else if (state == SWC_SLOT)
         begin
            dq_oe <= (timer < low_len - 16'd1) && (timer != 16'(`SWC_SLOT_CYC - 1));
         end
         else
         begin
            dq_oe <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp <= '0;
         busy <= 1'b0;
      end
      else
      begin
         cmd_ready <= (state == SWC_IDLE) && !cmd_valid;
         if (buf_out_ready)
         begin
            rsp_valid <= rsp_valid_w;
            rsp <= rsp_w;
         end
         busy <= (state != SWC_IDLE);
      end
   end

   a_rst_low_long: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(state == SWC_RST_LOW) |-> dq_oe [*8]) else $error("reset pulse too short");
   a_slot_recover: assert property (@(posedge clock) disable iff (!rst_n)
      (state == SWC_RECOVER) |-> !dq_oe) else $error("bus driven in recovery");
   a_pin_low_only: assert property (@(posedge clock) disable iff (!rst_n)
      !dq_out) else $error("bus driven high");
   a_read_release: assert property (@(posedge clock) disable iff (!rst_n)
      (state == SWC_SLOT && (op == SWC_OP_READ_BYTE || op == SWC_OP_READ_BIT)
       && timer == 16'(`SWC_RD_SAMPLE_CYC))
      |-> !dq_oe) else $error("bus held at read sample");
   a_write_one: assert property (@(posedge clock) disable iff (!rst_n)
      (state == SWC_SLOT && op == SWC_OP_WRITE_BYTE && shift[0]
       && timer == 16'(`SWC_W1_LOW_CYC + 1)) |-> !dq_oe) else $error("write one late");
   a_write_zero: assert property (@(posedge clock) disable iff (!rst_n)
      (state == SWC_SLOT && op == SWC_OP_WRITE_BYTE && !shift[0]
       && timer == 16'(`SWC_SLOT_CYC - 2)) |-> dq_oe) else $error("write zero short");
endmodule

// *** logic/swc_pkg.sv ***
// Types shared by the single-wire host controller
package swc_pkg;
   typedef enum logic [2:0] {
      SWC_OP_RESET,
      SWC_OP_WRITE_BYTE,
      SWC_OP_READ_BYTE,
      SWC_OP_WRITE_BIT,
      SWC_OP_READ_BIT
   } swc_op_t;

   typedef struct packed {
      swc_op_t op;
      logic [7:0] data;
   } swc_cmd_t;

   typedef struct packed {
      logic [7:0] data;
      logic presence;
   } swc_rsp_t;
endpackage

// *** logic/swc_regs.svh ***
// Timing counts, command codes and bus constants for the single-wire host
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
`define SWC_CLK_MHZ 50
`define SWC_RST_US 480
`define SWC_RST_CYC (`SWC_RST_US * `SWC_CLK_MHZ)
`define SWC_PRES_US 480
`define SWC_PRES_CYC (`SWC_PRES_US * `SWC_CLK_MHZ)
`define SWC_PRES_SAMPLE_US 70
`define SWC_PRES_SAMPLE_CYC (`SWC_PRES_SAMPLE_US * `SWC_CLK_MHZ)
`define SWC_SLOT_US 70
`define SWC_SLOT_CYC (`SWC_SLOT_US * `SWC_CLK_MHZ)
`define SWC_REC_US 2
`define SWC_REC_CYC (`SWC_REC_US * `SWC_CLK_MHZ)
`define SWC_W1_LOW_US 6
`define SWC_W1_LOW_CYC (`SWC_W1_LOW_US * `SWC_CLK_MHZ)
`define SWC_RD_LOW_US 2
`define SWC_RD_LOW_CYC (`SWC_RD_LOW_US * `SWC_CLK_MHZ)
`define SWC_RD_SAMPLE_US 12
`define SWC_RD_SAMPLE_CYC (`SWC_RD_SAMPLE_US * `SWC_CLK_MHZ)
`define SWC_ROM_SEARCH 8'hf0
`define SWC_ROM_READ 8'h33
`define SWC_ROM_MATCH 8'h55
`define SWC_ROM_SKIP 8'hcc
`define SWC_FN_WRITE 8'hcc
`define SWC_FN_READ 8'h33
`endif

// *** logic/swc_skid.sv ***
// Two-entry buffer for answers so a stalled consumer loses nothing
`timescale 1ns/1ps
module swc_skid
#(
   parameter int WIDTH = 9
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [0:1];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;

   assign in_ready = (count != 2'd2);
   assign out_valid = (count != 2'd0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clock)
   begin
      if (in_valid && in_ready)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'd0;
      end
      else
      begin
         if (in_valid && in_ready)
         begin
            wr_ptr <= ~wr_ptr;
         end
         if (out_valid && out_ready)
         begin
            rd_ptr <= ~rd_ptr;
         end
         case ({in_valid && in_ready, out_valid && out_ready})
            2'b10: count <= count + 2'd1;
            2'b01: count <= count - 2'd1;
            default: count <= count;
         endcase
      end
   end

   a_skid_no_over: assert property (@(posedge clock) disable iff (!rst_n)
      count <= 2'd2) else $error("buffer count overflow");
endmodule

// *** sim/swc_dev_model.sv ***
// Behavioural bus device: presence pulse, write sampling and identity read-out
`timescale 1ns/1ps
`include "swc_regs.svh"
module swc_dev_model
#(
   parameter logic [7:0] FAMILY = 8'h5a, // Arbitrary value
   parameter logic [47:0] SERIAL = 48'h1234_9abc_def0
)
(
   // Bus
   input wire logic bus,
   output logic dev_oe
);
   logic [63:0] id;
   logic [7:0] rx;
   logic smp;
   logic hit;
   int mode;
   int cnt;
   time t0;
   function automatic logic [7:0] crc8(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 56; i++)
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
      return c;
   endfunction
   assign id = {crc8({SERIAL, FAMILY}), SERIAL, FAMILY};
   initial
   begin
      dev_oe = 1'b0;
      mode = 0;
      cnt = 0;
      rx = 8'h00;
      hit = 1'b0;
      forever
      begin
         @(negedge bus);
         t0 = $time;
         if (mode == 2)
            dev_oe = ~id[cnt];
         #30000;
         smp = bus;
         // Held past the host's sample point, released well before the slot ends
         dev_oe = 1'b0;
         wait (bus === 1'b1);
         if ($time - t0 > 400000)
         begin
            #30000 dev_oe = 1'b1;
            #120000 dev_oe = 1'b0;
            mode = 1;
            cnt = 0;
         end
         else if (mode == 1)
         begin
            rx = {smp, rx[7:1]};
            cnt++;
            if (cnt == 8)
            begin
               // Unknown codes leave the device silent until the next reset
               mode = (rx == `SWC_ROM_READ) ? 2 : (rx == `SWC_ROM_SKIP) ? 3
                  : (rx == `SWC_ROM_MATCH) ? 4 : 0;
               cnt = 0;
               hit = 1'b1;
            end
         end
         else if (mode == 4)
         begin
            hit = hit && (smp == id[cnt]);
            cnt++;
            if (cnt == 64)
            begin
               mode = hit ? 3 : 0;
               cnt = 0;
            end
         end
         else if (mode == 3)
         begin
            rx = {smp, rx[7:1]};
            cnt++;
            if (cnt == 8)
            begin
               // Write and read both move to mode 5, where the device takes no further bytes
               mode = (rx == `SWC_FN_WRITE || rx == `SWC_FN_READ) ? 5 : 0;
               cnt = 0;
            end
         end
         else if (mode == 2)
         begin
            cnt++;
            if (cnt == 64)
               mode = 0;
         end
      end
   end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench: host engine against a behavioural bus device
`timescale 1ns/1ps
`include "swc_regs.svh"
module tb_top;
   import swc_pkg::*;
   localparam logic [7:0] FAM = 8'h5a;
   localparam logic [7:0] RD = `SWC_ROM_READ;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic rsp_ready = 1'b0;
   swc_cmd_t cmd = '0;
   logic cmd_ready, rsp_valid, dq_oe, dq_out, busy, dev_oe;
   logic prev = 1'b0;
   swc_rsp_t rsp, r;
   wire bus;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int run = 0;
   int lo_q[$];
   int hi_q[$];
   // Pull-up: the line is high unless some party pulls it low
   assign bus = ~(dq_oe | dev_oe);
   always #10 clock = ~clock;
   swc_host swc_host_i (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp(rsp), .dq_in(bus), .dq_out(dq_out), .dq_oe(dq_oe), .busy(busy));
   swc_dev_model #(.FAMILY(FAM)) swc_dev_model_i (.bus(bus), .dev_oe(dev_oe));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Compares %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Run lengths of the host's pull, low and high, for timing checks
   always @(posedge clock)
   begin
      cyc++;
      if (!rst_n)
      begin
         // Runs start at release so the unknown pin level in reset is not counted
         prev = 1'b0;
         run = 0;
      end
      else
      begin
         if (dq_oe === 1'b1)
            chk(dq_out, 1'b0);
         if (dq_oe !== prev)
         begin
            if (prev)
               lo_q.push_back(run);
            else
               hi_q.push_back(run);
            run = 1;
         end
         else
            run++;
         prev = dq_oe;
      end
      if (cyc == 100000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic do_cmd(input swc_op_t op, input logic [7:0] d, input logic poke);
      int n;
      n = 0;
      cmd_valid <= 1'b1;
      cmd <= {op, d};
      @(posedge clock);
      while (busy !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         n++;
      end
      if (busy !== 1'b1)
         error_cnt++;
      cmd_valid <= 1'b0;
      // A second offer while busy must be ignored
      if (poke)
      begin
         repeat (10) @(posedge clock);
         cmd_valid <= 1'b1;
         cmd <= {SWC_OP_WRITE_BYTE, 8'($urandom)};
         @(posedge clock);
         cmd_valid <= 1'b0;
      end
      n = 0;
      while (busy !== 1'b0 && n < 60000)
      begin
         @(posedge clock);
         n++;
      end
      if (busy !== 1'b0)
         error_cnt++;
   endtask
   task automatic get_rsp(output swc_rsp_t x);
      int n;
      n = 0;
      rsp_ready <= 1'b1;
      @(posedge clock);
      while (rsp_valid !== 1'b1 && n < 100)
      begin
         @(posedge clock);
         n++;
      end
      if (rsp_valid !== 1'b1)
         error_cnt++;
      x = rsp;
      rsp_ready <= 1'b0;
      // One edge passes so a following call never reassigns ready in this step
      @(posedge clock);
   endtask
   initial
   begin
      void'($urandom(32'h18dd189d));
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      do_cmd(SWC_OP_RESET, 8'($urandom), 1'b0);
      chk(cmd_ready, 1'b1);
      get_rsp(r);
      chk(r.presence, 1'b1);
      chk(lo_q[0] >= `SWC_RST_CYC, 1);
      do_cmd(SWC_OP_WRITE_BYTE, RD, 1'b1);
      get_rsp(r);
      chk(r.data, RD);
      repeat (5) @(posedge clock);
      chk(rsp_valid, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         chk(RD[i] ? lo_q[1+i] <= 750 : lo_q[1+i] >= 3000, 1);
         if (i < 7)
            chk(lo_q[1+i] + hi_q[2+i] >= 3000 && hi_q[2+i] >= 50, 1);
      end
      // Two answers wait while the consumer stalls, one in the output register and one in the buffer
      do_cmd(SWC_OP_READ_BIT, 8'($urandom), 1'b0);
      do_cmd(SWC_OP_READ_BIT, 8'($urandom), 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         if (i == 2)
            do_cmd(SWC_OP_READ_BIT, 8'($urandom), 1'b0);
         get_rsp(r);
         chk(r.data[0], FAM[i]);
      end
      for (int i = 9; i < 12; i++)
         chk(lo_q[i] >= 50 && lo_q[i] < 750, 1);
      print_verdict();
   end
endmodule
